// ==== src/rsil_pkg.sv ====
// Purpose: Shared constants for the receive serializer interrupt logic.
// Assumes: Byte-wide register file reached through the serial register port.
// Notes:   Offsets, field positions and reset values are named here once.
package rsil_pkg;

  // Register offsets on the serial register port.
  localparam logic [7:0] RSIL_ADDR_SERDES_CTRL = 8'h06;
  localparam logic [7:0] RSIL_ADDR_IRQ_ENABLE  = 8'h07;
  localparam logic [7:0] RSIL_ADDR_IRQ_STATUS  = 8'h08;
  localparam logic [7:0] RSIL_ADDR_DATA_A      = 8'h09;
  localparam logic [7:0] RSIL_ADDR_DATA_B      = 8'h0B;

  // Reset values.
  localparam logic [7:0] RSIL_RST_SERDES_CTRL = 8'h00;
  localparam logic [7:0] RSIL_RST_IRQ_ENABLE  = 8'h00;
  localparam logic [7:0] RSIL_RST_IRQ_STATUS  = 8'h00;
  localparam logic [7:0] RSIL_RST_DATA        = 8'h00;

  // Control register fields.
  localparam int RSIL_CTRL_EOF_LEN_LSB = 0;
  localparam int RSIL_CTRL_EOF_LEN_W   = 3;
  localparam logic [7:0] RSIL_CTRL_WMASK = 8'h0F;

  // Enable register bit positions.
  localparam int RSIL_EN_FULL_A  = 0;
  localparam int RSIL_EN_EOF_A   = 1;
  localparam int RSIL_EN_OVF_A   = 2;
  localparam int RSIL_EN_UNF_A   = 3;
  localparam int RSIL_EN_FULL_B  = 4;
  localparam int RSIL_EN_EOF_B   = 5;
  localparam int RSIL_EN_OVF_B   = 6;
  localparam int RSIL_EN_UNF_B   = 7;

  // Status register bit positions.
  localparam int RSIL_ST_FULL_A  = 0;
  localparam int RSIL_ST_EOF_A   = 1;
  localparam int RSIL_ST_FLOW_A  = 2;
  localparam int RSIL_ST_VALID_A = 3;
  localparam int RSIL_ST_FULL_B  = 4;
  localparam int RSIL_ST_EOF_B   = 5;
  localparam int RSIL_ST_FLOW_B  = 6;
  localparam int RSIL_ST_VALID_B = 7;

  // Bits per received byte.
  localparam logic [3:0] RSIL_BYTE_BITS = 4'h8;

  // Receiver framing states.
  typedef enum logic [1:0] {
    RSIL_IDLE  = 2'h1,
    RSIL_FRAME = 2'h2
  } rsil_state_t;

endpackage

// ==== src/rsil_chan.sv ====
// Purpose: One receive channel: byte assembly, end of frame, data register events.
// Assumes: bit_stb_in pulses once per bit time with the bit and its validity.
// Notes:   Events are one-cycle pulses; sticky flags live in the top module.
`timescale 1ns/1ps
module rsil_chan (
  input  wire logic                                   clk_in,
  input  wire logic                                   rst_in,
  input  wire logic                                   rx_on_in,
  input  wire logic [rsil_pkg::RSIL_CTRL_EOF_LEN_W-1:0] eof_len_in,
  input  wire logic                                   bit_stb_in,
  input  wire logic                                   bit_val_in,
  input  wire logic                                   bit_dat_in,
  input  wire logic                                   host_rd_in,
  output logic      [7:0]                             data_out,
  output logic                                        all_valid_out,
  output logic                                        full_evt_out,
  output logic                                        eof_evt_out,
  output logic                                        ovf_evt_out,
  output logic                                        unf_evt_out
);
  import rsil_pkg::*;

  rsil_state_t state_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic        byte_ok_reg;
  logic [2:0]  gap_cnt_reg;
  logic        full_reg;
  logic        eof_now;
  logic        byte_done;
  logic        load_now;

  // End of frame when the invalid bit count passes the programmed length.
  // R6: gap exceeds length
  // R7: zero length case
  assign eof_now   = bit_stb_in && (state_reg == RSIL_FRAME) && !bit_val_in
                     && (gap_cnt_reg == eof_len_in);
  assign byte_done = bit_stb_in && !eof_now
                     && ((state_reg == RSIL_FRAME) || bit_val_in)
                     && (bit_cnt_reg == RSIL_BYTE_BITS - 4'h1);
  // R10: complete or partial load
  assign load_now  = byte_done || (eof_now && (bit_cnt_reg != 4'h0));

  // Frame state: a valid bit opens a frame, end of frame closes it.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= RSIL_IDLE;
    end else if (!rx_on_in || eof_now) begin
      state_reg <= RSIL_IDLE;
    end else if (bit_stb_in && bit_val_in) begin
      state_reg <= RSIL_FRAME;
    end
  end

  // Invalid-bit gap counter, restarted by every valid bit.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_cnt_reg <= 3'h0;
    end else if (!rx_on_in || eof_now || (bit_stb_in && bit_val_in)) begin
      gap_cnt_reg <= 3'h0;
    end else if (bit_stb_in && (state_reg == RSIL_FRAME)) begin
      gap_cnt_reg <= gap_cnt_reg + 3'h1;
    end
  end

  // Byte assembly, first received bit lands in bit 0.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_ok_reg <= 1'b1;
    end else if (!rx_on_in || load_now || eof_now) begin
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_ok_reg <= 1'b1;
    end else if (bit_stb_in && ((state_reg == RSIL_FRAME) || bit_val_in)) begin
      shift_reg[bit_cnt_reg[2:0]] <= bit_dat_in;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      byte_ok_reg <= byte_ok_reg & bit_val_in;
    end
  end

  // Received data register and its validity, loaded on a transfer.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_out      <= RSIL_RST_DATA;
      all_valid_out <= 1'b0;
    end else if (load_now) begin
      data_out      <= byte_done ? {bit_dat_in, shift_reg[6:0]} : shift_reg;
      all_valid_out <= byte_done && byte_ok_reg && bit_val_in;
    end
  end

  // Data register occupancy: load fills it, a host read empties it.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      full_reg <= 1'b0;
    end else if (load_now) begin
      full_reg <= 1'b1;
    end else if (host_rd_in || !rx_on_in) begin
      full_reg <= 1'b0;
    end
  end

  // Event pulses towards the status register.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      full_evt_out <= 1'b0;
      eof_evt_out  <= 1'b0;
      ovf_evt_out  <= 1'b0;
      unf_evt_out  <= 1'b0;
    end else begin
      full_evt_out <= load_now;
      eof_evt_out  <= eof_now;
      // R4: load over unread byte
      ovf_evt_out  <= load_now && full_reg && !host_rd_in;
      // R2: read while empty
      unf_evt_out  <= host_rd_in && !full_reg && !load_now;
    end
  end

endmodule // rsil_chan

// ==== src/rsil_top.sv ====
// Purpose: Receive serializer interrupt enables, status flags and interrupt line.
// Assumes: The serial port decoder gives one-cycle read and write strobes.
// Notes:   Read data appears on the edge after the read strobe.
//
// Overview of operation
// R1: Enable bit 3 gates the channel A underflow interrupt.
// R2: Reading empty channel A data register is an underflow; a read in the same cycle as a load raises none.
// R3: Enable bit 2 gates the channel A overflow interrupt.
// R4: Loading channel A data before host read is an overflow.
// R5: Enable bit 1 gates the channel A end-of-frame interrupt.
// R6: End of frame follows a valid bit once invalid bits exceed length.
// R7: Length zero gives end of frame on first invalid bit.
// R8: End-of-frame flag holds until status register is read.
// R9: Enable bit 0 gates the channel A full interrupt.
// R10: Full event on every transfer into channel A data register.
// R11: Status at 0x08, reset 0x00, eight documented flag positions.
// R12: Bit 7 set when channel B byte is entirely valid; no interrupt.
// R13: Bit 6 set on channel B overflow or underflow.
// R14: Reading status clears channel B flow-violation flag.
// R15: Flags set regardless of enables, so polling works.
// R16: End-of-frame length is control register bits 2:0.
// R17: Status reads zero outside receive mode.
// R18: Interrupt high while any enabled flag is set.
// R19: Both channel A flow enables feed the one flow flag.
`timescale 1ns/1ps
module rsil_top (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       rx_mode_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic       a_bit_stb_in,
  input  wire logic       a_bit_val_in,
  input  wire logic       a_bit_dat_in,
  input  wire logic       b_bit_stb_in,
  input  wire logic       b_bit_val_in,
  input  wire logic       b_bit_dat_in,
  output logic [7:0]      reg_rdata_out,
  output logic            irq_out
);
  import rsil_pkg::*;

  logic [7:0] ctrl_reg;
  logic [7:0] enable_reg;
  logic [7:0] status_reg;
  logic       unf_a_reg;
  logic       ovf_a_reg;
  logic       unf_b_reg;
  logic       ovf_b_reg;
  logic [7:0] status_view;
  logic       stat_rd;
  logic       rd_a;
  logic       rd_b;
  logic [7:0] data_a;
  logic [7:0] data_b;
  logic       valid_a;
  logic       valid_b;
  logic       full_a;
  logic       full_b;
  logic       eof_a;
  logic       eof_b;
  logic       ovf_a;
  logic       ovf_b;
  logic       unf_a;
  logic       unf_b;
  logic [RSIL_CTRL_EOF_LEN_W-1:0] eof_len;

  // Sticky flag update: an event in the clearing cycle wins.
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // Read strobes per address.
  assign stat_rd = reg_rd_in && (reg_addr_in == RSIL_ADDR_IRQ_STATUS);
  assign rd_a    = reg_rd_in && (reg_addr_in == RSIL_ADDR_DATA_A);
  assign rd_b    = reg_rd_in && (reg_addr_in == RSIL_ADDR_DATA_B);
  // R16: length field
  assign eof_len = ctrl_reg[RSIL_CTRL_EOF_LEN_LSB +: RSIL_CTRL_EOF_LEN_W];
  // R17: zero outside receive
  assign status_view = rx_mode_in ? status_reg : 8'h00;

  // Channel A receiver.
  rsil_chan u_chan_a (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .rx_on_in      (rx_mode_in),
    .eof_len_in    (eof_len),
    .bit_stb_in    (a_bit_stb_in),
    .bit_val_in    (a_bit_val_in),
    .bit_dat_in    (a_bit_dat_in),
    .host_rd_in    (rd_a),
    .data_out      (data_a),
    .all_valid_out (valid_a),
    .full_evt_out  (full_a),
    .eof_evt_out   (eof_a),
    .ovf_evt_out   (ovf_a),
    .unf_evt_out   (unf_a)
  );

  // Channel B receiver.
  rsil_chan u_chan_b (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .rx_on_in      (rx_mode_in),
    .eof_len_in    (eof_len),
    .bit_stb_in    (b_bit_stb_in),
    .bit_val_in    (b_bit_val_in),
    .bit_dat_in    (b_bit_dat_in),
    .host_rd_in    (rd_b),
    .data_out      (data_b),
    .all_valid_out (valid_b),
    .full_evt_out  (full_b),
    .eof_evt_out   (eof_b),
    .ovf_evt_out   (ovf_b),
    .unf_evt_out   (unf_b)
  );

  // Writable control and enable registers.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg   <= RSIL_RST_SERDES_CTRL;
      enable_reg <= RSIL_RST_IRQ_ENABLE;
    end else if (reg_wr_in) begin
      if (reg_addr_in == RSIL_ADDR_SERDES_CTRL) begin
        ctrl_reg <= reg_wdata_in & RSIL_CTRL_WMASK;
      end
      if (reg_addr_in == RSIL_ADDR_IRQ_ENABLE) begin
        enable_reg <= reg_wdata_in;
      end
    end
  end

  // Status flags, set whatever the enables say.
  // R15: enable-independent flags
  // R11: status layout
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_reg <= RSIL_RST_IRQ_STATUS;
    end else begin
      // R10: full A on transfer
      status_reg[RSIL_ST_FULL_A]  <= sticky(status_reg[RSIL_ST_FULL_A], full_a, rd_a);
      // R8: end of frame cleared by status read
      status_reg[RSIL_ST_EOF_A]   <= sticky(status_reg[RSIL_ST_EOF_A], eof_a, stat_rd);
      status_reg[RSIL_ST_FLOW_A]  <= sticky(status_reg[RSIL_ST_FLOW_A], ovf_a | unf_a,
                                            stat_rd);
      if (full_a) begin
        status_reg[RSIL_ST_VALID_A] <= valid_a;
      end
      status_reg[RSIL_ST_FULL_B]  <= sticky(status_reg[RSIL_ST_FULL_B], full_b, rd_b);
      status_reg[RSIL_ST_EOF_B]   <= sticky(status_reg[RSIL_ST_EOF_B], eof_b, stat_rd);
      // R13: channel B flow violation
      // R14: cleared by status read
      status_reg[RSIL_ST_FLOW_B]  <= sticky(status_reg[RSIL_ST_FLOW_B], ovf_b | unf_b,
                                            stat_rd);
      // R12: valid B on load
      if (full_b) begin
        status_reg[RSIL_ST_VALID_B] <= valid_b;
      end
    end
  end

  // Cause of each flow violation, so each enable gates its own cause.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      unf_a_reg <= 1'b0;
      ovf_a_reg <= 1'b0;
      unf_b_reg <= 1'b0;
      ovf_b_reg <= 1'b0;
    end else begin
      unf_a_reg <= sticky(unf_a_reg, unf_a, stat_rd);
      ovf_a_reg <= sticky(ovf_a_reg, ovf_a, stat_rd);
      unf_b_reg <= sticky(unf_b_reg, unf_b, stat_rd);
      ovf_b_reg <= sticky(ovf_b_reg, ovf_b, stat_rd);
    end
  end

  // Interrupt line from enabled flags; valid flags never contribute.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      // R18: any enabled flag
      // R9: full A gate
      // R5: end of frame A gate
      // R3: overflow A gate
      // R1: underflow A gate
      // R19: shared flow flag
      irq_out <= rx_mode_in && (
        (enable_reg[RSIL_EN_FULL_A] && status_reg[RSIL_ST_FULL_A]) ||
        (enable_reg[RSIL_EN_EOF_A]  && status_reg[RSIL_ST_EOF_A])  ||
        (enable_reg[RSIL_EN_OVF_A]  && status_reg[RSIL_ST_FLOW_A] && ovf_a_reg) ||
        (enable_reg[RSIL_EN_UNF_A]  && status_reg[RSIL_ST_FLOW_A] && unf_a_reg) ||
        (enable_reg[RSIL_EN_FULL_B] && status_reg[RSIL_ST_FULL_B]) ||
        (enable_reg[RSIL_EN_EOF_B]  && status_reg[RSIL_ST_EOF_B])  ||
        (enable_reg[RSIL_EN_OVF_B]  && status_reg[RSIL_ST_FLOW_B] && ovf_b_reg) ||
        (enable_reg[RSIL_EN_UNF_B]  && status_reg[RSIL_ST_FLOW_B] && unf_b_reg));
    end
  end

  // Registered read data; unmapped addresses read as zero.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        RSIL_ADDR_SERDES_CTRL: reg_rdata_out <= ctrl_reg;
        RSIL_ADDR_IRQ_ENABLE:  reg_rdata_out <= enable_reg;
        RSIL_ADDR_IRQ_STATUS:  reg_rdata_out <= status_view;
        RSIL_ADDR_DATA_A:      reg_rdata_out <= data_a;
        RSIL_ADDR_DATA_B:      reg_rdata_out <= data_b;
        default:               reg_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule // rsil_top

// ==== bench/rsil_chk.sv ====
// Purpose: Port-level checker for the receive serializer interrupt logic.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Bound to the top module after the module body.
`timescale 1ns/1ps
module rsil_chk (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       rx_mode_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic       a_bit_stb_in,
  input wire logic       b_bit_stb_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       irq_out
);
  import rsil_pkg::*;
  logic quiet;
  logic rd_stat;
  // No bit strobes and no read other than the status read, so no flag can be set.
  assign quiet   = !a_bit_stb_in && !b_bit_stb_in && !(reg_rd_in && reg_addr_in != 8'h08);
  assign rd_stat = reg_rd_in && reg_addr_in == RSIL_ADDR_IRQ_STATUS;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reset_quiet_a: assert property ($fell(rst_in) |-> reg_rdata_out == 8'h00 && !irq_out)
    else $error("outputs not cleared by reset");
  rdata_hold_a: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (reg_rd_in && !(reg_addr_in inside {8'h06, 8'h07, 8'h08,
    8'h09, 8'h0B}) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  enable_readback_a: assert property (reg_wr_in && reg_addr_in == RSIL_ADDR_IRQ_ENABLE ##2
    reg_rd_in && reg_addr_in == RSIL_ADDR_IRQ_ENABLE |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("enable register read back wrong");
  ctrl_mask_a: assert property (reg_wr_in && reg_addr_in == RSIL_ADDR_SERDES_CTRL ##2
    reg_rd_in && reg_addr_in == RSIL_ADDR_SERDES_CTRL
    |=> reg_rdata_out == ($past(reg_wdata_in, 3) & RSIL_CTRL_WMASK))
    else $error("control register read back wrong");
  rx_off_irq_a: assert property (!rx_mode_in && !$past(rx_mode_in) |-> !irq_out)
    else $error("interrupt high outside receive mode");
  rx_off_status_a: assert property (rd_stat && !rx_mode_in |=> reg_rdata_out == 8'h00)
    else $error("status not zero outside receive mode");
  flag_clear_a: assert property (quiet [*3] ##1 (quiet && rd_stat) ##1 quiet ##1
    (quiet && rd_stat) |=> (reg_rdata_out & 8'h66) == 8'h00)
    else $error("status read left end-of-frame or flow flags set");
endmodule // rsil_chk

bind rsil_top rsil_chk chk_u (.clk_in(clk_in), .rst_in(rst_in), .rx_mode_in(rx_mode_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .a_bit_stb_in(a_bit_stb_in), .b_bit_stb_in(b_bit_stb_in),
  .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));

// ==== bench/rsil_host.sv ====
// Purpose: Host model that drives the serial register port strobes.
// Assumes: One access at a time, each strobe high for one cycle.
// Notes:   Read data is taken a half cycle after the answering edge.
`timescale 1ns/1ps
module rsil_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  // The port idles with no strobe and a parked address.
  initial begin
    addr_out  = 8'hFF;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  // Write one byte; the address is inverted once the strobe drops.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask
  // Read one byte; the answer is registered on the strobe edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask
endmodule // rsil_host

// ==== bench/rsil_top_tb_top.sv ====
// Purpose: Self-checking bench for the receive serializer interrupt logic.
// Assumes: Bits are strobed every other cycle, LSB first.
// Notes:   Expected values follow the status and enable bit layout.
`timescale 1ns/1ps
module rsil_top_tb_top;
  import rsil_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       rx_mode_in = 1'b1;
  logic [1:0] stb = 2'h0;
  logic [1:0] val = 2'h0;
  logic [1:0] dat = 2'h0;
  logic [7:0] addr, wdata, rdata, got;
  logic       wr, rd, irq;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cycles = 0;

  // Free-running clock.
  always #50 clk_in = ~clk_in;

  rsil_host host_u (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  rsil_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .rx_mode_in(rx_mode_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .a_bit_stb_in(stb[0]), .a_bit_val_in(val[0]), .a_bit_dat_in(dat[0]),
    .b_bit_stb_in(stb[1]), .b_bit_val_in(val[1]), .b_bit_dat_in(dat[1]),
    .reg_rdata_out(rdata), .irq_out(irq));

  // Compare and report a mismatch.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, got);
    check(got, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One bit time on a channel; qualifiers are inverted after the strobe.
  task automatic send(input int ch, input logic v, input logic d);
    @(posedge clk_in);
    stb[ch] <= 1'b1;
    val[ch] <= v;
    dat[ch] <= d;
    @(posedge clk_in);
    stb[ch] <= 1'b0;
    val[ch] <= ~v;
    dat[ch] <= ~d;
  endtask
  task automatic send_byte(input int ch, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      send(ch, 1'b1, b[i]);
    end
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      end_sim();
    end
  end

  // Main sequence of register accesses and received bits.
  initial begin
    idle(20);
    rst_in <= 1'b0;
    rd_chk(RSIL_ADDR_IRQ_STATUS, RSIL_RST_IRQ_STATUS);
    rd_chk(RSIL_ADDR_IRQ_ENABLE, RSIL_RST_IRQ_ENABLE);
    rd_chk(8'h3F, 8'h00);
    host_u.wr(RSIL_ADDR_SERDES_CTRL, 8'hF8);
    rd_chk(RSIL_ADDR_SERDES_CTRL, 8'h08);
    host_u.wr(RSIL_ADDR_IRQ_ENABLE, 8'h03);
    rd_chk(RSIL_ADDR_IRQ_ENABLE, 8'h03);
    send(0, 1'b1, 1'b1);
    send(0, 1'b0, 1'b0);
    idle(4);
    check({7'h00, irq}, 8'h01);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'h03);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'h01);
    rd_chk(RSIL_ADDR_DATA_A, 8'h01);
    idle(3);
    check({7'h00, irq}, 8'h00);
    host_u.wr(RSIL_ADDR_IRQ_ENABLE, 8'h04);
    host_u.rd(RSIL_ADDR_DATA_A, got);
    idle(3);
    check({7'h00, irq}, 8'h00);
    host_u.wr(RSIL_ADDR_IRQ_ENABLE, 8'h08);
    idle(2);
    check({7'h00, irq}, 8'h01);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'h04);
    host_u.wr(RSIL_ADDR_SERDES_CTRL, 8'h02);
    host_u.wr(RSIL_ADDR_IRQ_ENABLE, 8'h04);
    send_byte(0, 8'hA5);
    idle(4);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'h09);
    send_byte(0, 8'h3C);
    idle(4);
    check({7'h00, irq}, 8'h01);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'h0D);
    idle(2);
    check({7'h00, irq}, 8'h00);
    rd_chk(RSIL_ADDR_DATA_A, 8'h3C);
    send(0, 1'b0, 1'b0);
    send(0, 1'b0, 1'b0);
    idle(4);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'h08);
    send(0, 1'b0, 1'b0);
    idle(4);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'h03);
    host_u.rd(RSIL_ADDR_DATA_A, got);
    host_u.wr(RSIL_ADDR_IRQ_ENABLE, 8'hEF);
    send_byte(1, 8'hFF);
    idle(4);
    check({7'h00, irq}, 8'h00);
    rd_chk(RSIL_ADDR_DATA_B, 8'hFF);
    host_u.rd(RSIL_ADDR_DATA_B, got);
    idle(3);
    check({7'h00, irq}, 8'h01);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'hC0);
    idle(2);
    check({7'h00, irq}, 8'h00);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'h80);
    // A second byte lands on an unread channel B byte: overflow raises the flow flag.
    send_byte(1, 8'h5A);
    send_byte(1, 8'h5A);
    idle(4);
    check({7'h00, irq}, 8'h01);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'hD0);
    idle(2);
    check({7'h00, irq}, 8'h00);
    host_u.rd(RSIL_ADDR_DATA_A, got);
    idle(3);
    check({7'h00, irq}, 8'h01);
    @(posedge clk_in);
    rx_mode_in <= 1'b0;
    idle(2);
    check({7'h00, irq}, 8'h00);
    rd_chk(RSIL_ADDR_IRQ_STATUS, 8'h00);
    end_sim();
  end
endmodule // rsil_top_tb_top
